// *** dv/qsd_chk_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module qsd_chk (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sync_pin,
   input wire logic [5:0]  group_clk,
   input wire logic        sync_busy
);
   logic       sen_ff;
   logic       auto_ff;
   logic       ex0_ff;
   logic [7:0] div0_ff;
   logic [3:0] age_ff;
   logic [9:0] stall_ff;
   wire        wr = psel && penable && pready && pwrite;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////
   // shadow of the control bits and the group 0 config fields; only committed writes count
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sen_ff <= 1'b1;
         auto_ff <= 1'b0;
         ex0_ff <= 1'b0;
         div0_ff <= 8'h04;
      end else if (wr && paddr == 8'h18) begin
         sen_ff <= pwdata[0];
         auto_ff <= pwdata[2];
      end else if (wr && paddr == 8'h00) begin
         ex0_ff <= pwdata[17];
         div0_ff <= pwdata[7:0];
      end
   end
   // age of the last request cause, saturating so it never wraps
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) age_ff <= 4'hf;
      else if (wr || $changed(sync_pin)) age_ff <= 4'h0;
      else if (age_ff != 4'hf) age_ff <= age_ff + 4'h1;
   end
   // how long group 0 has stood still
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) stall_ff <= 10'h0;
      else if ($changed(group_clk[0]) || (wr && paddr == 8'h00)) stall_ff <= 10'h0;
      else if (stall_ff != 10'h3ff) stall_ff <= stall_ff + 10'h1;
   end
   ////////////////////////////////////////////////////////////////////////////
   chk_ready_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   // misaligned offsets are unmapped as well
   chk_err_decode: assert property (pready |-> pslverr == (paddr > 8'h1c || paddr[1:0] != 2'b00))
      else $error("slave error on wrong address");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   chk_auto_start:
      assert property (wr && paddr < 8'h18 && paddr[1:0] == 2'b00 && auto_ff && sen_ff
         && !sync_busy
         |-> ##[1:4] sync_busy) else $error("auto sync did not start");
   chk_enable_gate:
      assert property ($rose(sync_busy) |-> $past(sen_ff))
      else $error("sync ran while disabled");
   chk_busy_cause:
      assert property ($rose(sync_busy) |-> age_ff <= 4'd6)
      else $error("sync started without a cause");
   // a half period is div ticks; a sync hold would stretch it well beyond
   chk_exempt_runs:
      assert property (ex0_ff |-> stall_ff <= {2'b00, div0_ff} + 10'd2)
      else $error("exempt group stopped");
endmodule
bind qsd_core qsd_chk chk_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sync_pin(sync_pin), .group_clk(group_clk), .sync_busy(sync_busy));
`default_nettype wire

// *** dv/qsd_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module qsd_host (
   input  wire logic        clk,
   input  wire logic        pready,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   output logic             sync_pin
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      sync_pin = 1'b0;
   end
   // one transfer; request held until ready is sampled
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task pulse();
      @(posedge clk);
      sync_pin <= 1'b1;
      @(posedge clk);
      sync_pin <= 1'b0;
   endtask
endmodule
`default_nettype wire

// *** dv/qualified_sync_dynamic_delay_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module qualified_sync_dynamic_delay_test;
   logic        clk;
   logic        rstn;
   wire         psel, penable, pwrite, pready, pslverr, sync_pin, sync_busy;
   wire  [7:0]  paddr;
   wire  [31:0] pwdata, prdata;
   wire  [5:0]  group_clk;
   logic [32:0] exp_q[$];
   int          exp_gap[$];
   int          miscompares, n_compared, cyc, gap;
   logic        busy_q, gap_on;
   logic [31:0] rnd, v;
   logic [31:0] pre [4] = '{32'h83, 32'h83, 32'h8f, 32'h81};
   qsd_core dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sync_pin(sync_pin), .group_clk(group_clk), .sync_busy(sync_busy));
   qsd_host host (.clk(clk), .pready(pready), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sync_pin(sync_pin));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task conclude();
      if (miscompares == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      host.xfer(a, 1'b0, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // monitors: read data and the rise of group 1 after the sequence ends
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         conclude();
      end
      if (psel && penable && pready === 1'b1 && !pwrite)
         check({pslverr, prdata}, exp_q.pop_front());
      busy_q <= sync_busy;
      if (busy_q === 1'b1 && sync_busy === 1'b0) begin
         gap_on <= 1'b1;
         // gap counts edges since the edge that ended the sequence
         gap <= 1;
         // synced group parked low at the end
         check({32'h0, group_clk[1]}, 33'h0);
      end else if (gap_on) begin
         gap <= gap + 1;
         if (group_clk[1] === 1'b1) begin
            gap_on <= 1'b0;
            // rise comes two ticks after the delay: release flop, then output flop
            if (exp_gap.size() == 0) check(33'(gap), 33'h1ffff);
            else check(33'(gap), 33'(exp_gap.pop_front()));
         end
      end
   end
   initial begin
      rstn = 1'b0;
      miscompares = 0;
      n_compared = 0;
      cyc = 0;
      busy_q = 1'b0;
      gap_on = 1'b0;
      rnd = 32'd49;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      // reset values, then an unmapped place
      rd(8'h00, {1'b0, 32'h504});
      rd(8'h18, {1'b0, 32'h1});
      rd(8'h20, {1'b1, 32'h0});
      rd(8'h1c, {1'b0, 32'h0});
      for (int g = 3; g < 6; g++) begin
         rnd = lfsr(rnd);
         v = rnd & 32'h3ffff;
         host.xfer(8'(g * 4), 1'b1, v);
         rd(8'(g * 4), {1'b0, v});
      end
      host.xfer(8'h00, 1'b1, 32'h20004);
      // last pass drops qualification to reach the unqualified path
      for (int i = 0; i < 4; i++) begin
         // powered, buffered, delay 6 to 15, auto on the third pass
         host.xfer(8'h18, 1'b1, pre[i]);
         // third pass adds a half step on group 1
         host.xfer(8'h04, 1'b1, 32'((6 + 3 * i) << 8) | 32'h4 | (i == 2 ? 32'h10000 : 32'h0));
         exp_gap.push_back(2 * (6 + 3 * i) + 2 + (i == 2 ? 1 : 0));
         if (i == 0 || i == 3) host.pulse();
         else if (i == 1) host.xfer(8'h18, 1'b1, 32'h8b);
         wait (sync_busy === 1'b1);
         wait (sync_busy === 1'b0);
         repeat (40) @(posedge clk);
      end
      // disabled sync ignores the pin
      host.xfer(8'h18, 1'b1, 32'h82);
      host.pulse();
      repeat (30) @(posedge clk);
      check({32'h0, sync_busy}, 33'h0);
      rd(8'h18, {1'b0, 32'h82});
      repeat (4) @(posedge clk);
      conclude();
   end
endmodule
`default_nettype wire

// *** logic/qsd_core.v ***
// How it works
// - qualified mode waits on qualifying clock edges
// - feedback selector picks the qualifying group
// - exempt qualifier keeps delay: absolute adjust
// - non-exempt qualifier is resynced too: relative
// - exempt groups never stop toggling unless PD45 gates group 2
// - half-step bit gives half-cycle delay step
// - half-step change acts at once
// - delay count latched only at sync
// - auto mode: writing group regs 0-5 syncs
// - one-shot 3 cycles after qualify, 3 wide
// - one-shot turns synced outputs off, on
// - one-shot follows second qualifying falling edge
// - outputs forced low 5 cycles after shot start
// - rise 5 plus delay cycles after shot end
// - pin or polarity toggle starts sync, any width
// - unqualified resync phase is undefined vs runners
// - unqualified: synced outputs held low while sync asserted
// - sync enable gates every sync event
// - polarity bit toggle asserts sync like pin
// - timing counted in distribution-path cycles
`timescale 1ns/1ps
`default_nettype none
`include "qsd_defs.vh"
module qsd_core (
   input  wire        clk,
   input  wire        rstn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        sync_pin,
   output wire [5:0]  group_clk,
   output reg         sync_busy
);
   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_HOLD = 3'd1;
   localparam [2:0] S_REL  = 3'd2;
   localparam [2:0] S_EDG1 = 3'd3;
   localparam [2:0] S_EDG2 = 3'd4;
   localparam [2:0] S_PRE  = 3'd5;
   localparam [2:0] S_SHOT = 3'd6;

   // address decode shared by read and write paths
   function grp_hit;
      input [7:0] a;
      begin
         grp_hit = (a[1:0] == 2'b00) && (a[7:2] < `QSD_NUM_GRP);
      end
   endfunction

   reg  [8:0]  ctrl_ff;
   reg  [2:0]  state_ff;
   reg  [2:0]  nxt_state;
   reg  [7:0]  cnt_ff;
   reg  [7:0]  nxt_cnt;
   reg         hold_c;
   reg         go_c;
   reg         shot_ff;
   reg         pin_s1_ff;
   reg         pin_s2_ff;
   reg         lvl_d_ff;
   reg         auto_ff;
   reg         qclk_d_ff;
   wire [17:0] grp_cfg [0:5];
   wire [5:0]  raw_out;
   wire [5:0]  held;
   wire        wr_acc;
   wire        sync_lvl;
   wire        req;
   wire        qclk;
   wire        qfall;

   ////////////////////////////////////////////////////////////////////////
   // apb slave: answer in the access phase, zero wait states
   assign wr_acc = psel & penable & pwrite & pready;

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~(grp_hit(paddr) |
                    (paddr == `QSD_CTRL_ADDR) | (paddr == `QSD_STAT_ADDR));
         prdata  <= 32'h0;
         if (psel & ~penable & ~pwrite) begin
            if (grp_hit(paddr))
               prdata <= {14'h0, grp_cfg[paddr[4:2]]};
            else if (paddr == `QSD_CTRL_ADDR)
               prdata <= {23'h0, ctrl_ff};
            else if (paddr == `QSD_STAT_ADDR)
               // one-shot flag sits next to the state so software can see it
               prdata <= {16'h0, 2'b00, held, 4'h0, shot_ff, state_ff};
         end
      end
   end

   // control register; toggling the polarity bit flips the sync level
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         ctrl_ff <= `QSD_C_RESET;
      else if (wr_acc && paddr == `QSD_CTRL_ADDR)
         ctrl_ff <= pwdata[8:0];
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         auto_ff <= 1'b0;
      else
         auto_ff <= wr_acc & grp_hit(paddr) & ctrl_ff[`QSD_C_AUTO_EN];
   end

   ////////////////////////////////////////////////////////////////////////
   // two-flop pin synchroniser
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
         lvl_d_ff  <= 1'b0;
         qclk_d_ff <= 1'b0;
      end else begin
         pin_s1_ff <= sync_pin;
         pin_s2_ff <= pin_s1_ff;
         lvl_d_ff  <= sync_lvl;
         qclk_d_ff <= qclk;
      end
   end

   // polarity bit xor pin gives asserted level
   assign sync_lvl = pin_s2_ff ^ ctrl_ff[`QSD_C_POL_INV];
   // edge detect, so pulse width is free
   assign req = ctrl_ff[`QSD_C_SYNC_EN] & ((sync_lvl & ~lvl_d_ff) | auto_ff);
   // qualifier chosen by feedback selector
   // internal clock already lives in clk domain, no extra crossing needed;
   // it only reaches the sync logic when the buffer and group 2 are up
   assign qclk = raw_out[ctrl_ff[`QSD_C_FB_MSB:`QSD_C_FB_LSB] % `QSD_NUM_GRP]
                 & ctrl_ff[`QSD_C_FB_BUF_EN] & ~ctrl_ff[`QSD_C_PD45];
   assign qfall = qclk_d_ff & ~qclk;

   ////////////////////////////////////////////////////////////////////////
   // sync sequencer, counts in half-cycle ticks
   // two ticks make one distribution cycle
   always @* begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff + 8'h01;
      hold_c    = 1'b0;
      go_c      = 1'b0;
      case (state_ff)
         S_IDLE: begin
            nxt_cnt = 8'h00;
            // qualified requests wait for the clock
            if (req)
               nxt_state = ctrl_ff[`QSD_C_QUAL_EN] ? S_EDG1 : S_HOLD;
         end
         S_HOLD: begin
            hold_c  = 1'b1;
            nxt_cnt = 8'h00;
            if (!sync_lvl)
               nxt_state = S_REL;
         end
         S_REL: begin
            // no reference: phase vs runners undefined
            if (cnt_ff == `QSD_UNQ_T - 1) begin
               go_c      = 1'b1;
               nxt_state = S_IDLE;
            end
         end
         S_EDG1: begin
            if (qfall)
               nxt_state = S_EDG2;
         end
         S_EDG2: begin
            nxt_cnt = 8'h00;
            if (qfall)
               nxt_state = S_PRE;
         end
         S_PRE: begin
            if (cnt_ff == `QSD_PRE_T - 1) begin
               nxt_cnt   = 8'h00;
               nxt_state = S_SHOT;
            end
         end
         S_SHOT: begin
            // force low 5 cycles after start
            if (cnt_ff == `QSD_LOW_T)
               hold_c = 1'b1;
            // release 5 cycles after shot end
            if (cnt_ff == `QSD_SHOT_T + `QSD_RISE_T) begin
               go_c      = 1'b1;
               nxt_state = S_IDLE;
            end
         end
         default: nxt_state = S_IDLE;
      endcase
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff  <= S_IDLE;
         cnt_ff    <= 8'h00;
         shot_ff   <= 1'b0;
         sync_busy <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         cnt_ff    <= nxt_cnt;
         shot_ff   <= (nxt_state == S_SHOT) && (nxt_cnt < `QSD_SHOT_T);
         sync_busy <= (nxt_state != S_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-group divider, delay and output stage
   genvar g;
   generate
      for (g = 0; g < `QSD_NUM_GRP; g = g + 1) begin : grp
         reg  [17:0] cfg_ff;
         reg  [8:0]  wait_ff;
         reg  [8:0]  ph_ff;
         reg         pend_ff;
         reg         held_ff;
         reg         raw_ff;
         reg         raw_d_ff;
         reg         out_ff;
         wire [7:0]  div;
         wire [8:0]  last;
         wire        aff;
         assign div  = (cfg_ff[7:0] == 8'h00) ? 8'h01 : cfg_ff[7:0];
         assign last = {div, 1'b0} - 9'h001;
         assign aff  = ~cfg_ff[`QSD_G_EXEMPT_BIT];
         assign grp_cfg[g] = cfg_ff;
         assign raw_out[g] = raw_ff;
         assign held[g]    = held_ff;
         assign group_clk[g] = out_ff;

         always @(posedge clk or negedge rstn) begin
            if (!rstn)
               cfg_ff <= `QSD_G_RESET;
            else if (wr_acc && grp_hit(paddr) && paddr[4:2] == g)
               cfg_ff <= pwdata[17:0];
         end

         always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               wait_ff <= 9'h000;
               ph_ff   <= 9'h000;
               pend_ff <= 1'b0;
               held_ff <= 1'b0;
               raw_ff  <= 1'b0;
            end else if (hold_c && aff) begin
               held_ff <= 1'b1;
               pend_ff <= 1'b0;
               raw_ff  <= 1'b0;
            end else if (go_c && aff) begin
               pend_ff <= 1'b1;
               held_ff <= 1'b1;
               raw_ff  <= 1'b0;
               wait_ff <= {cfg_ff[`QSD_G_DLY_MSB:`QSD_G_DLY_LSB], 1'b0};
            end else if (pend_ff) begin
               if (wait_ff == 9'h000) begin
                  pend_ff <= 1'b0;
                  held_ff <= 1'b0;
                  ph_ff   <= 9'h000;
                  raw_ff  <= 1'b1;
               end else begin
                  wait_ff <= wait_ff - 9'h001;
               end
            end else if (!held_ff) begin
               ph_ff  <= (ph_ff >= last) ? 9'h000 : ph_ff + 9'h001;
               raw_ff <= ((ph_ff >= last) ? 9'h000 : ph_ff + 9'h001) < {1'b0, div};
            end
         end

         // half step delays output one tick
         always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               raw_d_ff <= 1'b0;
               out_ff   <= 1'b0;
            end else begin
               raw_d_ff <= raw_ff;
               out_ff   <= (cfg_ff[`QSD_G_HS_BIT] ? raw_d_ff : raw_ff) &
                           ~((g == 2) & ctrl_ff[`QSD_C_PD45]);
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// *** logic/qsd_defs.vh ***
`ifndef QSD_DEFS_VH
`define QSD_DEFS_VH
// register byte addresses; group config registers sit at index 0..5
`define QSD_GRP_BASE     8'h00
`define QSD_NUM_GRP      6
`define QSD_CTRL_ADDR    8'h18
`define QSD_STAT_ADDR    8'h1c
// group config fields
`define QSD_G_DIV_LSB    0
`define QSD_G_DIV_MSB    7
`define QSD_G_DLY_LSB    8
`define QSD_G_DLY_MSB    15
`define QSD_G_HS_BIT     16
`define QSD_G_EXEMPT_BIT 17
`define QSD_G_RESET      18'h00504
// control fields
`define QSD_C_SYNC_EN    0
`define QSD_C_QUAL_EN    1
`define QSD_C_AUTO_EN    2
`define QSD_C_POL_INV    3
`define QSD_C_FB_LSB     4
`define QSD_C_FB_MSB     6
`define QSD_C_FB_BUF_EN  7
`define QSD_C_PD45       8
`define QSD_C_RESET      9'h001
// one distribution cycle is two clk ticks, so half steps exist
`define QSD_TICKS_PER_CYC 2
`define QSD_PRE_CYC      3
`define QSD_SHOT_CYC     3
`define QSD_LOW_CYC      5
`define QSD_RISE_CYC     5
`define QSD_UNQ_CYC      6
`define QSD_PRE_T   (`QSD_PRE_CYC * `QSD_TICKS_PER_CYC)
`define QSD_SHOT_T  (`QSD_SHOT_CYC * `QSD_TICKS_PER_CYC)
`define QSD_LOW_T   (`QSD_LOW_CYC * `QSD_TICKS_PER_CYC)
`define QSD_RISE_T  (`QSD_RISE_CYC * `QSD_TICKS_PER_CYC)
`define QSD_UNQ_T   (`QSD_UNQ_CYC * `QSD_TICKS_PER_CYC)
`endif
